// ===== core/event_queue.sv
// arrival-order queue of pending event numbers
`timescale 1ns/100ps
`default_nettype none
module event_queue
(
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         reset,
    // queue port
    event_queue_if.store      q
);
    typedef struct packed {
        logic [erac_pkg::QUEUE_DEPTH-1:0][erac_pkg::EVENT_W-1:0] mem;
        logic [erac_pkg::QUEUE_PTR_W-1:0]                        wr;
        logic [erac_pkg::QUEUE_PTR_W-1:0]                        rd;
    } queue_state_type;

    queue_state_type s_q;
    queue_state_type s_d;
    logic            full;
    logic            empty;

    assign empty        = (s_q.wr == s_q.rd);
    assign full         = (s_q.wr[2:0] == s_q.rd[2:0]) && !empty;
    assign q.push_ready = !full;
    assign q.pop_valid  = !empty;
    assign q.pop_event  = s_q.mem[s_q.rd[2:0]];

    always_comb
    begin
        s_d = s_q;
        if (q.push_valid && !full)
        begin
            s_d.mem[s_q.wr[2:0]] = q.push_event;
            s_d.wr = s_q.wr + 4'h1;
        end
        if (q.pop_ready && !empty)
            s_d.rd = s_q.rd + 4'h1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            s_q.mem <= '0;
            s_q.wr  <= '0;
            s_q.rd  <= '0;
        end
        else
            s_q <= s_d;
    end

    property p_fifo_first;
        @(posedge sys_clk) disable iff (reset)
        (empty && q.push_valid) |=> (q.pop_valid
            && q.pop_event == $past(q.push_event));
    endproperty
    a_fifo_first: assert property (p_fifo_first)
        else $error("first pushed event is not at the head");

    property p_fifo_full;
        @(posedge sys_clk) disable iff (reset)
        (full && !q.pop_ready) |=> (full && $stable(s_q.wr));
    endproperty
    a_fifo_full: assert property (p_fifo_full)
        else $error("full queue accepted a push");
endmodule // event_queue
`default_nettype wire

// ===== core/event_routine_attach_controller.sv
// event binding table, occurrence queueing and routine dispatch
`timescale 1ns/100ps
`default_nettype none
module event_routine_attach_controller
#(
    parameter logic [1:0] VARIANT = erac_pkg::VARIANT_LARGE
)
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset,
    // bind and unbind requests
    input  wire logic       req_valid,
    input  wire logic       req_bind,
    input  wire logic [7:0] req_event,
    input  wire logic [7:0] req_routine,
    input  wire logic       runtime_fault_bit,
    input  wire logic       fast_counter_conflict,
    output logic            req_done,
    output logic            success_flag,
    output logic [15:0]     error_code,
    // global enable control
    input  wire logic       enable_all,
    input  wire logic       disable_all,
    input  wire logic       run_entry,
    output logic            global_enable,
    // edge inputs from pins
    input  wire logic [3:0] edge_pin,
    // serial ports
    input  wire logic       port0_rx_char,
    input  wire logic       port0_tx_done,
    input  wire logic       port0_msg_done,
    input  wire logic       port1_rx_char,
    input  wire logic       port1_tx_done,
    input  wire logic       port1_msg_done,
    // periodic and timer sources
    input  wire logic [1:0] timed_tick,
    input  wire logic [1:0] time_equals_preset,
    input  wire logic [1:0] pulse_train_done,
    // fast counters: bit 0 equal, bit 1 direction, bit 2 reset
    input  wire logic [2:0] fast_counter0_evt,
    input  wire logic [2:0] fast_counter1_evt,
    input  wire logic [2:0] fast_counter2_evt,
    input  wire logic [2:0] fast_counter4_evt,
    input  wire logic       fast_counter3_eq,
    input  wire logic       fast_counter5_eq,
    // routine dispatch
    output logic            disp_valid,
    input  wire logic       disp_ready,
    output logic [5:0]      disp_event,
    output logic [7:0]      disp_routine
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [33:0]                             bound;
        logic [33:0][erac_pkg::ROUTINE_W-1:0]    routine;
        logic [33:0]                             pending;
        logic                                    gie;
        logic [3:0]                              sync1;
        logic [3:0]                              sync2;
        logic [3:0]                              prev;
        erac_pkg::disp_state_type                st;
        logic [5:0]                              dev;
        logic [7:0]                              drt;
        logic                                    done;
        logic                                    ok;
        logic [15:0]                             err;
    } ctrl_state_type;

    ctrl_state_type s_q;
    ctrl_state_type s_d;
    logic [33:0]    mask;
    logic [33:0]    raw;
    logic [7:0]     edge_raw;
    logic [33:0]    live;
    logic           accepted;
    logic [5:0]     ev;
    logic [5:0]     low_idx;
    logic           pick_ok;

    event_queue_if qi();

    event_queue u_queue
    (
        .sys_clk (sys_clk),
        .reset   (reset),
        .q       (qi.store)
    );

    // ----------------------------------------
    // variant and source mapping
    // ----------------------------------------
    assign mask = (VARIANT == erac_pkg::VARIANT_SMALL) ? erac_pkg::MASK_SMALL
                : (VARIANT == erac_pkg::VARIANT_MID)   ? erac_pkg::MASK_MID
                : erac_pkg::MASK_LARGE;
    assign ev       = req_event[5:0];
    assign accepted = (req_event < 8'(erac_pkg::EVENT_COUNT))
                      && mask[ev];

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_edge
            // even number on rise, odd on fall
            assign edge_raw[2*gi]   =
                s_q.sync2[gi] && !s_q.prev[gi];
            assign edge_raw[2*gi+1] =
                !s_q.sync2[gi] && s_q.prev[gi];
        end
    endgenerate

    always_comb
    begin
        raw = '0;
        raw[erac_pkg::EV_EDGE_BASE+:8] = edge_raw;
        raw[erac_pkg::EV_P0_RX]  = port0_rx_char;
        raw[erac_pkg::EV_P0_TX]  = port0_tx_done;
        raw[erac_pkg::EV_P0_MSG] = port0_msg_done;
        raw[erac_pkg::EV_P1_MSG] = port1_msg_done;
        raw[erac_pkg::EV_P1_RX]  = port1_rx_char;
        raw[erac_pkg::EV_P1_TX]  = port1_tx_done;
        raw[erac_pkg::EV_TIMED_BASE+:2] = timed_tick;
        raw[erac_pkg::EV_C0_EQ]  = fast_counter0_evt[0];
        raw[erac_pkg::EV_C0_DIR] = fast_counter0_evt[1];
        raw[erac_pkg::EV_C0_RST] = fast_counter0_evt[2];
        raw[erac_pkg::EV_C1_BASE+:3] = fast_counter1_evt;
        raw[erac_pkg::EV_C2_BASE+:3] = fast_counter2_evt;
        raw[erac_pkg::EV_C4_BASE+:3] = fast_counter4_evt;
        raw[erac_pkg::EV_C3_EQ]  = fast_counter3_eq;
        raw[erac_pkg::EV_C5_EQ]  = fast_counter5_eq;
        raw[erac_pkg::EV_PULSE_BASE+:2] = pulse_train_done;
        raw[erac_pkg::EV_TIMER_BASE+:2] = time_equals_preset;
    end

    // sources absent from this variant never count
    assign live = raw[33:0] & mask & s_q.bound;

    always_comb
    begin
        low_idx = '0;
        pick_ok = 1'b0;
        for (int i = erac_pkg::EVENT_COUNT - 1; i >= 0; i--)
        begin
            if (s_q.pending[i])
            begin
                low_idx = 6'(i);
                pick_ok = 1'b1;
            end
        end
    end

    // ----------------------------------------
    // queue handshake
    // ----------------------------------------
    assign qi.push_valid = pick_ok;
    assign qi.push_event = low_idx;
    assign qi.pop_ready  = s_q.gie && (s_q.st == erac_pkg::ST_IDLE);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        s_d       = s_q;
        s_d.done  = 1'b0;
        s_d.sync1 = edge_pin;
        s_d.sync2 = s_q.sync1;
        s_d.prev  = s_q.sync2;
        // one occurrence per event is held while waiting for the queue
        if (pick_ok && qi.push_ready)
            s_d.pending[low_idx] = 1'b0;
        s_d.pending = s_d.pending | live;
        if (enable_all)
            s_d.gie = 1'b1;
        if (disable_all || run_entry)
            s_d.gie = 1'b0;
        if (req_valid)
        begin
            s_d.done = 1'b1;
            s_d.ok   = 1'b0;
            if (!accepted)
                s_d.err = erac_pkg::ERR_RANGE;
            else if (!req_bind)
            begin
                s_d.bound[ev]   = 1'b0;
                s_d.pending[ev] = 1'b0;
                s_d.ok  = 1'b1;
                s_d.err = erac_pkg::ERR_NONE;
            end
            else if (runtime_fault_bit)
                s_d.err = erac_pkg::ERR_FAULT;
            else if (fast_counter_conflict)
                s_d.err = erac_pkg::ERR_CONFLICT;
            else
            begin
                // overwrite keeps one routine per event
                s_d.routine[ev] = req_routine;
                s_d.bound[ev]   = 1'b1;
                s_d.ok  = 1'b1;
                s_d.err = erac_pkg::ERR_NONE;
            end
        end
        case (s_q.st)
            erac_pkg::ST_IDLE:
            begin
                // stale entries of detached events are dropped here
                if (qi.pop_ready && qi.pop_valid
                    && s_q.bound[qi.pop_event])
                begin
                    s_d.st  = erac_pkg::ST_OFFER;
                    s_d.dev = qi.pop_event;
                    s_d.drt = s_q.routine[qi.pop_event];
                end
            end
            erac_pkg::ST_OFFER:
            begin
                if (disp_ready)
                    s_d.st = erac_pkg::ST_IDLE;
            end
            default:
                s_d.st = erac_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            s_q.bound   <= '0;
            s_q.routine <= '0;
            s_q.pending <= '0;
            s_q.gie     <= 1'b0;
            s_q.sync1   <= '0;
            s_q.sync2   <= '0;
            s_q.prev    <= '0;
            s_q.st      <= erac_pkg::ST_IDLE;
            s_q.dev     <= '0;
            s_q.drt     <= '0;
            s_q.done    <= 1'b0;
            s_q.ok      <= erac_pkg::SUCCESS_RST;
            s_q.err     <= erac_pkg::ERR_NONE;
        end
        else
            s_q <= s_d;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign req_done      = s_q.done;
    assign success_flag  = s_q.ok;
    assign error_code    = s_q.err;
    assign global_enable = s_q.gie;
    assign disp_valid    = (s_q.st == erac_pkg::ST_OFFER);
    assign disp_event    = s_q.dev;
    assign disp_routine  = s_q.drt;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    property p_bind_sets;
        (req_valid && req_bind && accepted && !runtime_fault_bit
         && !fast_counter_conflict) |=> (s_q.bound[$past(ev)]
         && s_q.routine[$past(ev)] == $past(req_routine) && success_flag);
    endproperty
    a_bind_sets: assert property (p_bind_sets)
        else $error("bind did not store routine and enable");

    property p_unbind_clears;
        (req_valid && !req_bind && accepted) |=>
            (!s_q.bound[$past(ev)] && !s_q.pending[$past(ev)]);
    endproperty
    a_unbind_clears: assert property (p_unbind_clears)
        else $error("unbind left event enabled");

    property p_fault_fails;
        (req_valid && req_bind && accepted && runtime_fault_bit) |=>
            (req_done && !success_flag && error_code == 16'h0001);
    endproperty
    a_fault_fails: assert property (p_fault_fails)
        else $error("faulted bind reported success");

    property p_conflict_code;
        (req_valid && req_bind && accepted && !runtime_fault_bit
         && fast_counter_conflict) |=>
            (!success_flag && error_code == 16'h0002
             && $stable(s_q.bound));
    endproperty
    a_conflict_code: assert property (p_conflict_code)
        else $error("counter conflict not reported as 0002");

    property p_range;
        (req_valid && !accepted) |=> (!success_flag && $stable(s_q.bound));
    endproperty
    a_range: assert property (p_range)
        else $error("unaccepted event number changed the table");

    property p_bound_dispatch;
        $rose(disp_valid) |-> ($past(s_q.bound[qi.pop_event])
            && disp_event == $past(qi.pop_event)
            && disp_routine == $past(s_q.routine[qi.pop_event]));
    endproperty
    a_bound_dispatch: assert property (p_bound_dispatch)
        else $error("dispatch without current binding");

    property p_gie_blocks;
        !global_enable |=> !$rose(disp_valid);
    endproperty
    a_gie_blocks: assert property (p_gie_blocks)
        else $error("dispatch while globally disabled");

    property p_run_entry;
        (run_entry && !enable_all) ##1 (!enable_all)[*2] |->
            !global_enable;
    endproperty
    a_run_entry: assert property (p_run_entry)
        else $error("run entry left interrupts enabled");

    property p_unbound_ignored;
        ((s_q.pending & ~$past(s_q.pending))
         & ~$past(raw & mask & s_q.bound)) == 34'h0;
    endproperty
    a_unbound_ignored: assert property (p_unbound_ignored)
        else $error("unbound occurrence was queued");

    property p_edge_map;
        (s_q.sync2[0] && !s_q.prev[0] && s_q.bound[0]) |=>
            s_q.pending[0] || $past(qi.push_valid && low_idx == 6'h0);
    endproperty
    a_edge_map: assert property (p_edge_map)
        else $error("rising edge of input 0 lost");
endmodule // event_routine_attach_controller
`default_nettype wire

// ===== pkg/erac_pkg.sv
// constants for the event routine attach controller
package erac_pkg;
    // ----------------------------------------
    // sizes and variants
    // ----------------------------------------
    localparam int EVENT_COUNT   = 34;
    localparam int EVENT_W       = 6;
    localparam int ROUTINE_W     = 8;
    localparam int QUEUE_DEPTH   = 8;
    localparam int QUEUE_PTR_W   = 4;
    localparam logic [1:0] VARIANT_SMALL = 2'h0;
    localparam logic [1:0] VARIANT_MID   = 2'h1;
    localparam logic [1:0] VARIANT_LARGE = 2'h2;
    localparam logic [33:0] MASK_SMALL = 34'h3_f8f8_1fff;
    localparam logic [33:0] MASK_MID   = 34'h3_f8ff_ffff;
    localparam logic [33:0] MASK_LARGE = 34'h3_ffff_ffff;
    // ----------------------------------------
    // event numbers
    // ----------------------------------------
    localparam int EV_EDGE_BASE  = 0;
    localparam int EV_P0_RX      = 8;
    localparam int EV_P0_TX      = 9;
    localparam int EV_TIMED_BASE = 10;
    localparam int EV_C0_EQ      = 12;
    localparam int EV_C1_BASE    = 13;
    localparam int EV_C2_BASE    = 16;
    localparam int EV_PULSE_BASE = 19;
    localparam int EV_TIMER_BASE = 21;
    localparam int EV_P0_MSG     = 23;
    localparam int EV_P1_MSG     = 24;
    localparam int EV_P1_RX      = 25;
    localparam int EV_P1_TX      = 26;
    localparam int EV_C0_DIR     = 27;
    localparam int EV_C0_RST     = 28;
    localparam int EV_C4_BASE    = 29;
    localparam int EV_C3_EQ      = 32;
    localparam int EV_C5_EQ      = 33;
    // ----------------------------------------
    // answer codes and reset values
    // ----------------------------------------
    localparam logic [15:0] ERR_NONE     = 16'h0000;
    localparam logic [15:0] ERR_FAULT    = 16'h0001;
    localparam logic [15:0] ERR_CONFLICT = 16'h0002;
    localparam logic [15:0] ERR_RANGE    = 16'h00ff;
    localparam logic        SUCCESS_RST  = 1'b1;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_OFFER = 2'b10
    } disp_state_type;
endpackage

// ===== pkg/event_queue_if.sv
// carrier between the controller and its arrival-order queue
`timescale 1ns/100ps
`default_nettype none
interface event_queue_if;
    logic       push_valid;
    logic       push_ready;
    logic [5:0] push_event;
    logic       pop_valid;
    logic       pop_ready;
    logic [5:0] pop_event;
    modport client (output push_valid, push_event, pop_ready,
                    input  push_ready, pop_valid, pop_event);
    modport store  (input  push_valid, push_event, pop_ready,
                    output push_ready, pop_valid, pop_event);
endinterface
`default_nettype wire

// ===== tb/dispatch_taker.sv
// processor model that takes routine dispatches
`timescale 1ns/100ps
`default_nettype none
module dispatch_taker
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset,
    // stall cycles before taking an offer
    input  wire logic [3:0] stall,
    // dispatch port
    input  wire logic       disp_valid,
    output logic            disp_ready,
    input  wire logic [5:0] disp_event,
    input  wire logic [7:0] disp_routine
);
    logic [5:0] log_ev[$];
    logic [7:0] log_rt[$];
    logic [3:0] wait_q;

    // ready only while an offer stands, dropped right after the take
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            disp_ready <= 1'b0;
            wait_q     <= 4'h0;
        end
        else if (disp_valid && disp_ready)
        begin
            log_ev.push_back(disp_event);
            log_rt.push_back(disp_routine);
            disp_ready <= 1'b0;
            wait_q     <= 4'h0;
        end
        else if (disp_valid && wait_q >= stall)
            disp_ready <= 1'b1;
        else if (disp_valid)
            wait_q <= wait_q + 4'h1;
    end
endmodule // dispatch_taker
`default_nettype wire

// ===== tb/event_routine_attach_controller_tb_top.sv
// self-checking bench for the event routine attach controller
`timescale 1ns/100ps
`default_nettype none
module event_routine_attach_controller_tb_top;
    logic        sys_clk     = 1'b0;
    logic        reset       = 1'b1;
    logic        req_valid   = 1'b0;
    logic        req_bind    = 1'b0;
    logic [7:0]  req_event   = 8'h00;
    logic [7:0]  req_routine = 8'h00;
    logic        fault       = 1'b0;
    logic        conflict    = 1'b0;
    logic [2:0]  glob        = 3'h0;
    logic [3:0]  edge_pin    = 4'h0;
    logic [33:0] src         = 34'h0;
    logic [3:0]  stall       = 4'h0;
    logic        req_done;
    logic        success_flag;
    logic        global_enable;
    logic [15:0] error_code;
    logic        disp_valid;
    logic        disp_ready;
    logic [5:0]  disp_event;
    logic [7:0]  disp_routine;
    logic        small_ok;
    logic [15:0] small_err;
    int          num_errors  = 0;
    int          compares    = 0;
    int          cycles      = 0;
    int          seen_idx    = 0;

    event_routine_attach_controller i_dut (
        .sys_clk(sys_clk), .reset(reset),
        .req_valid(req_valid), .req_bind(req_bind),
        .req_event(req_event), .req_routine(req_routine),
        .runtime_fault_bit(fault), .fast_counter_conflict(conflict),
        .req_done(req_done), .success_flag(success_flag),
        .error_code(error_code),
        .enable_all(glob[2]), .disable_all(glob[1]),
        .run_entry(glob[0]), .global_enable(global_enable),
        .edge_pin(edge_pin),
        .port0_rx_char(src[8]), .port0_tx_done(src[9]),
        .port0_msg_done(src[23]), .port1_rx_char(src[25]),
        .port1_tx_done(src[26]), .port1_msg_done(src[24]),
        .timed_tick(src[11:10]), .time_equals_preset(src[22:21]),
        .pulse_train_done(src[20:19]),
        .fast_counter0_evt({src[28], src[27], src[12]}),
        .fast_counter1_evt(src[15:13]),
        .fast_counter2_evt(src[18:16]),
        .fast_counter4_evt(src[31:29]),
        .fast_counter3_eq(src[32]), .fast_counter5_eq(src[33]),
        .disp_valid(disp_valid), .disp_ready(disp_ready),
        .disp_event(disp_event), .disp_routine(disp_routine));

    dispatch_taker i_proc (
        .sys_clk(sys_clk), .reset(reset), .stall(stall),
        .disp_valid(disp_valid), .disp_ready(disp_ready),
        .disp_event(disp_event), .disp_routine(disp_routine));

    // smallest variant, watched only for its narrower accepted range
    event_routine_attach_controller #(
        .VARIANT(erac_pkg::VARIANT_SMALL)) i_dut_small (
        .sys_clk(sys_clk), .reset(reset),
        .req_valid(req_valid), .req_bind(req_bind),
        .req_event(req_event), .req_routine(req_routine),
        .runtime_fault_bit(fault), .fast_counter_conflict(conflict),
        .req_done(), .success_flag(small_ok),
        .error_code(small_err),
        .enable_all(glob[2]), .disable_all(glob[1]),
        .run_entry(glob[0]), .global_enable(),
        .edge_pin(edge_pin),
        .port0_rx_char(src[8]), .port0_tx_done(src[9]),
        .port0_msg_done(src[23]), .port1_rx_char(src[25]),
        .port1_tx_done(src[26]), .port1_msg_done(src[24]),
        .timed_tick(src[11:10]), .time_equals_preset(src[22:21]),
        .pulse_train_done(src[20:19]),
        .fast_counter0_evt({src[28], src[27], src[12]}),
        .fast_counter1_evt(src[15:13]),
        .fast_counter2_evt(src[18:16]),
        .fast_counter4_evt(src[31:29]),
        .fast_counter3_eq(src[32]), .fast_counter5_eq(src[33]),
        .disp_valid(), .disp_ready(1'b1),
        .disp_event(), .disp_routine());

    initial
    begin
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic request(input logic is_bind, input logic [7:0] ev,
        input logic [7:0] rt, input logic flt, input logic cfl,
        input logic ok, input logic [15:0] code);
        @(posedge sys_clk);
        req_valid   <= 1'b1;
        req_bind    <= is_bind;
        req_event   <= ev;
        req_routine <= rt;
        fault       <= flt;
        conflict    <= cfl;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        fault     <= 1'b0;
        conflict  <= 1'b0;
        #1;
        check(16'(req_done), 16'h0001);
        check(16'(success_flag), 16'(ok));
        check(error_code, code);
    endtask

    // one-cycle pulse on enable_all, disable_all, run_entry
    task automatic ctl(input logic [2:0] v);
        @(posedge sys_clk);
        glob <= v;
        @(posedge sys_clk);
        glob <= 3'h0;
    endtask

    // edge events: even number rising, odd number falling
    task automatic fire(input int ev);
        @(posedge sys_clk);
        if (ev < 8)
            edge_pin[ev / 2] <= (ev % 2 == 0);
        else
            src[ev] <= 1'b1;
        @(posedge sys_clk);
        src <= 34'h0;
    endtask

    task automatic expect_disp(input logic [5:0] ev, input logic [7:0] rt);
        int n;
        n = 0;
        while (i_proc.log_ev.size() <= seen_idx && n < 60)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (i_proc.log_ev.size() > seen_idx)
        begin
            check(16'(i_proc.log_ev[seen_idx]), 16'(ev));
            check(16'(i_proc.log_rt[seen_idx]), 16'(rt));
            seen_idx++;
        end
        else
            check(16'hffff, 16'(ev));
    endtask

    task automatic expect_none(input int n);
        repeat (n) @(posedge sys_clk);
        check(16'(i_proc.log_ev.size()), 16'(seen_idx));
    endtask

    task automatic src_run(input int lo, input int hi);
        for (int ev = lo; ev <= hi; ev++)
        begin
            request(1'b1, 8'(ev), 8'(ev + 64), 1'b0, 1'b0, 1'b1, 16'h0);
            fire(ev);
            expect_disp(6'(ev), 8'(ev + 64));
        end
    endtask

    task automatic t_reset();
        @(posedge sys_clk);
        #1;
        check(16'(success_flag), 16'h0001);
        check(error_code, 16'h0000);
        check(16'(global_enable), 16'h0000);
        check(16'(disp_valid), 16'h0000);
        $display("test reset done");
    endtask

    task automatic t_sources();
        ctl(3'b100);
        #1;
        check(16'(global_enable), 16'h0001);
        src_run(0, 7);
        src_run(8, 9);
        src_run(23, 23);
        src_run(24, 26);
        src_run(10, 11);
        src_run(12, 12);
        src_run(27, 28);
        src_run(13, 18);
        src_run(29, 31);
        src_run(32, 33);
        src_run(19, 20);
        src_run(21, 22);
        $display("test sources done");
    endtask

    task automatic t_share_rebind();
        request(1'b1, 8'd12, 8'h05, 1'b0, 1'b0, 1'b1, 16'h0);
        request(1'b1, 8'd32, 8'h05, 1'b0, 1'b0, 1'b1, 16'h0);
        request(1'b1, 8'd12, 8'h07, 1'b0, 1'b0, 1'b1, 16'h0);
        fire(12);
        expect_disp(6'd12, 8'h07);
        fire(32);
        expect_disp(6'd32, 8'h05);
        $display("test share_rebind done");
    endtask

    task automatic t_unbind_errors();
        request(1'b0, 8'd12, 8'h00, 1'b0, 1'b0, 1'b1, 16'h0);
        fire(12);
        expect_none(30);
        request(1'b0, 8'd33, 8'h00, 1'b0, 1'b0, 1'b1, 16'h0);
        request(1'b1, 8'd33, 8'h11, 1'b1, 1'b0, 1'b0, 16'h0001);
        request(1'b1, 8'd33, 8'h11, 1'b0, 1'b1, 1'b0, 16'h0002);
        request(1'b1, 8'd34, 8'h11, 1'b0, 1'b0, 1'b0, 16'h00ff);
        request(1'b1, 8'hff, 8'h11, 1'b0, 1'b0, 1'b0, 16'h00ff);
        request(1'b1, 8'd13, 8'h11, 1'b0, 1'b0, 1'b1, 16'h0);
        check(16'(small_ok), 16'h0000);
        check(small_err, 16'h00ff);
        fire(33);
        expect_none(30);
        $display("test unbind_errors done");
    endtask

    // slow processor here, so offers wait on the far side
    task automatic t_queue();
        ctl(3'b010);
        stall <= 4'h3;
        #1;
        check(16'(global_enable), 16'h0000);
        fire(10);
        fire(21);
        fire(12);
        fire(9);
        expect_none(20);
        ctl(3'b100);
        expect_disp(6'd10, 8'd74);
        expect_disp(6'd21, 8'd85);
        expect_disp(6'd9, 8'd73);
        expect_none(30);
        stall <= 4'h0;
        $display("test queue done");
    endtask

    task automatic t_run_entry();
        ctl(3'b001);
        #1;
        check(16'(global_enable), 16'h0000);
        fire(11);
        expect_none(20);
        ctl(3'b100);
        expect_disp(6'd11, 8'd75);
        $display("test run_entry done");
    endtask

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            num_errors++;
            complete_run();
        end
    end

    initial
    begin
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset();
        t_sources();
        t_share_rebind();
        t_unbind_errors();
        t_queue();
        t_run_entry();
        complete_run();
    end
endmodule // event_routine_attach_controller_tb_top
`default_nettype wire
